// [src/lcsr_consts.vh]
// constants for the led current setting register bank
// assumes inclusion by lcsr_regs.v and lcsr_standby_timer.v
`ifndef LCSR_CONSTS_VH
`define LCSR_CONSTS_VH

// ==========================================================
// register addresses
`define LCSR_ADDR_CODE_LOW      8'hA0
`define LCSR_ADDR_CODE_HIGH     8'hA1

// ==========================================================
// field positions
`define LCSR_CODE_LOW_MSB       7
`define LCSR_CODE_LOW_LSB       0
`define LCSR_CODE_HIGH_MSB      3
`define LCSR_CODE_HIGH_LSB      0
`define LCSR_MAXSEL_MSB         6
`define LCSR_MAXSEL_LSB         4
`define LCSR_STANDBY_EN_BIT     7

// ==========================================================
// reset values
`define LCSR_RST_CODE_LOW       8'hFF
`define LCSR_RST_CODE_HIGH      8'h5F
`define LCSR_RST_RES_EN         1'b0

// ==========================================================
// timing
`define LCSR_CLK_HZ             20000000
`define LCSR_STANDBY_MS         50
`define LCSR_STANDBY_CYCLES     ((`LCSR_CLK_HZ / 1000) * `LCSR_STANDBY_MS)
`define LCSR_CODE_FULL_SCALE    12'hFFF

`endif

// [src/lcsr_standby_timer.v]
// pwm-low standby timer
// assumes pwm_low is already synchronised to clk
`include "lcsr_consts.vh"
`default_nettype none

module lcsr_standby_timer #(
  parameter integer CYCLES = `LCSR_STANDBY_CYCLES
) (
  input  wire clk,
  input  wire rst,
  input  wire enable,
  input  wire pwm_low,
  output reg  standby
);

  reg [31:0] count_q;

  // ==========================================================
  // count continuous low time, restart on any high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 32'h00000000;
      standby <= 1'b0;
    end else if (!enable || !pwm_low) begin
      count_q <= 32'h00000000;
      standby <= 1'b0;
    end else if (count_q >= CYCLES - 1) begin
      standby <= 1'b1;
    end else begin
      count_q <= count_q + 32'h00000001;
    end
  end

endmodule

`default_nettype wire

// [src/lcsr_regs.v]
// led current setting registers with standby detection
// assumes a byte register port on clk, pwm dimming pin asynchronous
`include "lcsr_consts.vh"
`default_nettype none

// Functional notes
// - code bits 7:0 are read-write storage in the low current register.
// - the 12-bit code n sets the sink current to n/4095 of the maximum.
// - with resistor scaling off, current comes from the code and max field 6:4 only.
// - with resistor scaling on, current is further scaled by 20000 x 1.2V / resistor.
// - with standby enable set, standby follows about 50 ms of continuous pwm low.
module lcsr_regs #(
  parameter integer STANDBY_CYCLES = `LCSR_STANDBY_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        resistor_scaling_enable,
  input  wire        pwm_pin,
  output reg  [7:0]  reg_rdata,
  output reg  [11:0] current_code,
  output reg  [2:0]  selected_max_current,
  output reg         resistor_scaling_active,
  output reg         pwm_low_standby_enable,
  output reg         standby
);

  reg  [7:0] code_low_q;
  reg  [7:0] code_high_q;
  reg  [1:0] pwm_sync_q;
  reg  [1:0] res_sync_q;
  wire       standby_d;

  // ==========================================================
  // register storage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      code_low_q  <= `LCSR_RST_CODE_LOW;
      code_high_q <= `LCSR_RST_CODE_HIGH;
    end else if (reg_wr) begin
      if (reg_addr == `LCSR_ADDR_CODE_LOW)
        code_low_q <= reg_wdata;
      else if (reg_addr == `LCSR_ADDR_CODE_HIGH)
        code_high_q <= reg_wdata;
    end
  end

  // ==========================================================
  // readback, unmapped reads zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `LCSR_ADDR_CODE_LOW)
        reg_rdata <= code_low_q;
      else if (reg_addr == `LCSR_ADDR_CODE_HIGH)
        reg_rdata <= code_high_q;
      else
        reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // pin synchronisers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_sync_q <= 2'b11;
      res_sync_q <= 2'b00;
    end else begin
      pwm_sync_q <= {pwm_sync_q[0], pwm_pin};
      res_sync_q <= {res_sync_q[0], resistor_scaling_enable};
    end
  end

  // ==========================================================
  // settings to the analog sinks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      current_code            <= 12'h000;
      selected_max_current    <= 3'h0;
      resistor_scaling_active <= `LCSR_RST_RES_EN;
      pwm_low_standby_enable  <= 1'b0;
      standby                 <= 1'b0;
    end else begin
      // code n gives n/full-scale of max, zero gives no current
      current_code <= {code_high_q[`LCSR_CODE_HIGH_MSB:`LCSR_CODE_HIGH_LSB],
                       code_low_q};
      selected_max_current <= code_high_q[`LCSR_MAXSEL_MSB:`LCSR_MAXSEL_LSB];
      // analog stage applies resistor factor when this is high
      resistor_scaling_active <= res_sync_q[1];
      pwm_low_standby_enable  <= code_high_q[`LCSR_STANDBY_EN_BIT];
      standby                 <= standby_d;
    end
  end

  lcsr_standby_timer #(
    .CYCLES (STANDBY_CYCLES)
  ) u_timer (
    .clk     (clk),
    .rst     (rst),
    .enable  (code_high_q[`LCSR_STANDBY_EN_BIT]),
    .pwm_low (~pwm_sync_q[1]),
    .standby (standby_d)
  );

endmodule

`default_nettype wire

// [tb/lcsr_regs_props.sv]
// checker for the led current setting register bank
// assumes binding to lcsr_regs, clk rising, rst active high
`default_nettype none
module lcsr_regs_props (
  input wire logic        clk, rst, reg_wr, reg_rd, resistor_scaling_enable, pwm_pin,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
  input wire logic [11:0] current_code,
  input wire logic [2:0]  selected_max_current,
  input wire logic        resistor_scaling_active, pwm_low_standby_enable, standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_code_low_wr: assert property (s_wr(8'hA0) |-> ##2 current_code[7:0] == $past(reg_wdata, 2))
    else $error("low code byte not taken");
  a_code_high_wr: assert property (s_wr(8'hA1) |-> ##2 current_code[11:8] == $past(reg_wdata[3:0], 2))
    else $error("high code nibble not taken");
  a_max_sel_wr: assert property (s_wr(8'hA1) |-> ##2 selected_max_current == $past(reg_wdata[6:4], 2))
    else $error("max select not taken");
  a_stby_en_wr: assert property (s_wr(8'hA1) |-> ##2 pwm_low_standby_enable == $past(reg_wdata[7], 2))
    else $error("standby enable not taken");
  a_stby_needs_en: assert property ($rose(standby) |-> pwm_low_standby_enable && !pwm_pin)
    else $error("standby without enable");
  a_stby_drop: assert property ($fell(pwm_low_standby_enable) |-> ##[0:4] !standby)
    else $error("standby stays after disable");
  a_scale_follow: assert property ($stable(resistor_scaling_enable) [*5] |-> resistor_scaling_active == resistor_scaling_enable)
    else $error("scaling enable not followed");
  a_unmapped_rd: assert property (reg_rd && reg_addr[7:1] != 7'h50 ##1 !reg_rd |-> ##1 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd [*2] |-> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule
bind lcsr_regs lcsr_regs_props lcsr_regs_props_i (.*);
`default_nettype wire

// [tb/lcsr_host_model.sv]
// host controller model driving the register port
// assumes clk from the bench, requests launched 1 ns after an edge
`default_nettype none
module lcsr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0
);
  timeunit 1ns; timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1 reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge clk); #1 reg_wr = 1'b0; reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); #1 reg_addr = a; reg_rd = 1'b1;
    @(posedge clk); #1 reg_rd = 1'b0;
    @(posedge clk); #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// [tb/lcsr_regs_tb.sv]
// self-checking bench for lcsr_regs
// assumes a short standby count of 20 cycles
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module lcsr_regs_tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rst = 0, scale_pin = 0, pwm = 1, wr, rd, act, en, stby;
  logic [7:0] addr, wd, rdat, d; logic [11:0] code; logic [2:0] mx;
  int error_cnt = 0, cmp_count = 0;
  always #25 clk = ~clk;
  lcsr_host_model host_i (.clk(clk), .reg_rdata(rdat), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd));
  lcsr_regs #(.STANDBY_CYCLES(20)) lcsr_regs_i (.clk(clk), .rst(rst), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .resistor_scaling_enable(scale_pin),
    .pwm_pin(pwm), .reg_rdata(rdat), .current_code(code), .selected_max_current(mx),
    .resistor_scaling_active(act), .pwm_low_standby_enable(en), .standby(stby));
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_fields;
    `CHK({en, mx, code}, 16'h5FFF)
    host_i.wr(8'hA0, 8'h5A); host_i.wr(8'hA1, 8'hBC);
    host_i.rd(8'hA0, d); `CHK(d, 8'h5A)
    host_i.rd(8'hA1, d); `CHK(d, 8'hBC)
    host_i.rd(8'hA7, d); `CHK(d, 8'h00)
    `CHK({en, mx, code}, 16'hBC5A)
  endtask
  task automatic t_standby;
    #1 pwm = 0; repeat (30) @(posedge clk); #1 `CHK(stby, 1'b1)
    host_i.wr(8'hA1, 8'h3C); repeat (6) @(posedge clk); #1 `CHK(stby, 1'b0)
    pwm = 1;
  endtask
  task automatic t_scale;
    scale_pin = 1; repeat (5) @(posedge clk); #1 `CHK(act, 1'b1)
    scale_pin = 0; repeat (5) @(posedge clk); #1 `CHK(act, 1'b0)
  endtask
  initial begin
    // raise reset as a real edge so the asynchronous reset branches run
    #1 rst = 1;
    repeat (3) @(posedge clk); #1 rst = 0; repeat (2) @(posedge clk); #1;
    t_fields; t_standby; t_scale; end_of_test;
  end
  initial begin
    #20000; error_cnt++; end_of_test;
  end
endmodule
`default_nettype wire
